// [pss_frame_timer.sv]
// Frame timer: one-cycle tick at the end of every frame while running.
// Assumes the caller clears it with restart at the start of a new frame.
`timescale 1ns/1ps
module pss_frame_timer
    import pss_pkg::*;
#(
    parameter int unsigned FRAME_LEN = FRAME_CYCLES
) (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Control.
    input  wire logic run,
    input  wire logic restart,
    // Frame end pulse.
    output logic      frame_tick
);

    logic [FRAME_CNT_W-1:0] count;
    logic [FRAME_CNT_W-1:0] next_count;
    logic                   next_frame_tick;

    // Counts frame cycles; halts when not running and restarts at zero.
    always_comb begin
        next_count      = count;
        next_frame_tick = 1'b0;
        if (restart) begin
            next_count = '0;
        end else if (run) begin
            if (count == FRAME_CNT_W'(FRAME_LEN - 1)) begin
                next_count      = '0;
                next_frame_tick = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    // Registers the timer.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            count      <= '0;
            frame_tick <= 1'b0;
        end else begin
            count      <= next_count;
            frame_tick <= next_frame_tick;
        end
    end

endmodule

// [pss_host_model.sv]
// Host microprocessor model that drives the parallel bus of the power save block.
// Assumes the device synchronises the strobes and wants them six cycles low and high.
`timescale 1ns/1ps
module pss_host_model
    import pss_pkg::*;
(
    // Clock.
    input  wire logic              clk_sys,
    // Bus pins toward the device.
    output logic                   host_cs_n,
    output logic                   host_wr_n,
    output logic                   host_rd_n,
    output logic                   host_a0,
    output logic      [ADDR_W-1:0] host_addr,
    output logic      [DATA_W-1:0] host_data_bus_in,
    // Device side of the data bus.
    input  wire logic [DATA_W-1:0] host_data_bus_out,
    input  wire logic              host_data_bus_oe_n
);
    // The bus starts idle with every strobe high.
    initial begin
        host_cs_n = 1'b1;
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        host_a0 = 1'b0;
        host_addr = 5'h08;
        host_data_bus_in = 8'h00;
    end

    // One write, strobe held six cycles each way; released data lines show the inverse.
    task automatic wr(input logic a0, input logic [DATA_W-1:0] data);
        @(posedge clk_sys);
        host_cs_n <= 1'b0;
        host_wr_n <= 1'b0;
        host_a0 <= a0;
        host_data_bus_in <= data;
        repeat (6) @(posedge clk_sys);
        host_cs_n <= 1'b1;
        host_wr_n <= 1'b1;
        host_data_bus_in <= ~data;
        repeat (6) @(posedge clk_sys);
    endtask

    // One read of the power save register; ok stays low when the device never drives.
    task automatic rd(output logic ok, output logic [DATA_W-1:0] data);
        ok = 1'b0;
        data = 8'h00;
        @(posedge clk_sys);
        host_cs_n <= 1'b0;
        host_rd_n <= 1'b0;
        for (int i = 0; i < 12 && !ok; i++) begin
            @(posedge clk_sys);
            if (host_data_bus_oe_n === 1'b0) begin
                ok = 1'b1;
                data = host_data_bus_out;
            end
        end
        host_cs_n <= 1'b1;
        host_rd_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule

// [pss_pkg.sv]
// Package for the LCD power save control block: register map, commands, pin groups.
// Assumes one 200 MHz system clock and a host that drives the parallel bus pins.
package pss_pkg;

    // Clock rate and frame timing.
    localparam int unsigned CLK_HZ         = 200_000_000;
    localparam int unsigned FRAME_RATE_HZ  = 70;
    localparam int unsigned FRAME_CYCLES   = CLK_HZ / FRAME_RATE_HZ;
    localparam int          FRAME_CNT_W    = 22;

    // Host bus layout.
    localparam int          ADDR_W         = 5;
    localparam int          DATA_W         = 8;
    localparam int          PIN_SYNC_W     = 4;

    // Register offset, field position and reset value of the power save register.
    localparam logic [ADDR_W-1:0] REG_POWER_SAVE_CONTROL = 5'h08;
    localparam int                PSE_BIT                = 0;
    localparam logic [DATA_W-1:0] POWER_SAVE_RESET       = 8'h01;

    // Indirect mode command codes; the power save code value is arbitrary.
    localparam logic [DATA_W-1:0] CMD_SYS_CONFIG  = 8'h40;
    localparam logic [DATA_W-1:0] CMD_POWER_SAVE  = 8'h5f;
    localparam logic [3:0]        SYS_CONFIG_PARAMS = 4'h8;

    // Dummy writes the host owes after leaving power save in direct mode.
    localparam logic [1:0] DIRECT_DUMMY_WRITES = 2'h1;

    // Panel pin group.
    typedef struct packed {
        logic       frame_pulse;
        logic       line_pulse;
        logic       pixel_shift_clock;
        logic       lcd_ac_polarity;
        logic       column_enable_chain_clock;
        logic       row_shift_clock;
        logic       column_driver_control;
        logic [3:0] panel_pixel_data;
    } pss_scan_t;

    // Display memory control pin group.
    typedef struct packed {
        logic chip_enable_n;
        logic output_enable_n;
        logic write_enable_n;
    } pss_mem_t;

    // Fixed panel levels while parked.
    localparam pss_scan_t PANEL_PARKED = '{
        frame_pulse: 1'b0, line_pulse: 1'b0, pixel_shift_clock: 1'b0,
        lcd_ac_polarity: 1'b0, column_enable_chain_clock: 1'b0,
        row_shift_clock: 1'b1, column_driver_control: 1'b1,
        panel_pixel_data: 4'h0};

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_RUN,
        ST_BLANK,
        ST_SAVE
    } pss_state_t;

endpackage

// [pss_power_save.sv]
// Power save sequencer of a monochrome LCD controller, with its host bus port.
// Assumes the timing generator feeds scan_in and obeys scan_clk_en.
`timescale 1ns/1ps
module pss_power_save
    import pss_pkg::*;
#(
    parameter int unsigned FRAME_LEN = FRAME_CYCLES
) (
    // Clock and reset.
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // Host bus pins.
    input  wire logic              host_cs_n,
    input  wire logic              host_wr_n,
    input  wire logic              host_rd_n,
    input  wire logic              host_a0,
    input  wire logic [ADDR_W-1:0] host_addr,
    input  wire logic              direct_addressing,
    input  wire logic [DATA_W-1:0] host_data_bus_in,
    output logic      [DATA_W-1:0] host_data_bus_out,
    output logic                   host_data_bus_oe_n,
    output logic                   host_wait_n,
    output logic                   host_wait_oe_n,
    // Display control and timing generator.
    input  wire logic              display_enable,
    input  wire pss_scan_t         scan_in,
    input  wire pss_mem_t          mem_in,
    output logic                   scan_clk_en,
    output logic                   config_done,
    // Panel and memory pins.
    output pss_scan_t              panel_out,
    output logic                   row_driver_disable_n,
    output pss_mem_t               mem_out
);

    // Pin synchronisers: a change counts once the second and third stages agree.
    logic [PIN_SYNC_W-1:0] pin_raw;
    logic [PIN_SYNC_W-1:0] sync1;
    logic [PIN_SYNC_W-1:0] sync2;
    logic [PIN_SYNC_W-1:0] sync3;
    logic [PIN_SYNC_W-1:0] pin_stable;
    assign pin_raw = {host_cs_n, host_wr_n, host_rd_n, direct_addressing};
    for (genvar i = 0; i < PIN_SYNC_W; i++) begin : g_sync
        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                sync1[i]      <= 1'b1;
                sync2[i]      <= 1'b1;
                sync3[i]      <= 1'b1;
                pin_stable[i] <= 1'b1;
            end else begin
                sync1[i] <= pin_raw[i];
                sync2[i] <= sync1[i];
                sync3[i] <= sync2[i];
                if (sync2[i] == sync3[i]) begin
                    pin_stable[i] <= sync3[i];
                end
            end
        end
    end

    logic cs_n_s;
    logic wr_n_s;
    logic rd_n_s;
    logic direct_s;
    logic wr_n_d;
    logic wr_strobe;
    assign {cs_n_s, wr_n_s, rd_n_s, direct_s} = pin_stable;
    assign wr_strobe = wr_n_d && !wr_n_s && !cs_n_s;

    // Sequencer and register state.
    pss_state_t       state;
    pss_state_t       next_state;
    logic             pse;
    logic             next_pse;
    logic             tick_seen;
    logic             next_tick_seen;
    logic             in_sys_config;
    logic             next_in_sys_config;
    logic [3:0]       param_cnt;
    logic [3:0]       next_param_cnt;
    logic             next_config_done;
    logic [1:0]       dummy_pend;
    logic [1:0]       next_dummy_pend;
    logic             frame_tick;
    logic             timer_restart;
    logic             park;

    assign timer_restart = (state != ST_RUN) && !pse;

    // Frame timer; it halts in the low-power state.
    pss_frame_timer #(
        .FRAME_LEN (FRAME_LEN)
    ) u_frame_timer (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .run        (state != ST_SAVE),
        .restart    (timer_restart),
        .frame_tick (frame_tick)
    );

    // Host writes, register bit and state sequencing.
    always_comb begin
        next_pse           = pse;
        next_in_sys_config = in_sys_config;
        next_param_cnt     = param_cnt;
        next_config_done   = config_done;
        next_dummy_pend    = dummy_pend;
        next_state         = state;
        next_tick_seen     = tick_seen;
        if (wr_strobe) begin
            if (direct_s) begin
                if (dummy_pend != 2'h0) begin
                    next_dummy_pend = dummy_pend - 2'h1;
                end else if (host_addr == REG_POWER_SAVE_CONTROL) begin
                    next_pse = host_data_bus_in[PSE_BIT];
                    if (!host_data_bus_in[PSE_BIT]) begin
                        next_config_done = 1'b1;
                        if (pse) begin
                            next_dummy_pend = DIRECT_DUMMY_WRITES;
                        end
                    end
                end
            end else if (host_a0) begin
                next_in_sys_config = 1'b0;
                next_param_cnt     = 4'h0;
                if (host_data_bus_in == CMD_POWER_SAVE) begin
                    next_pse = 1'b1;
                end else if (host_data_bus_in == CMD_SYS_CONFIG) begin
                    next_in_sys_config = 1'b1;
                    next_config_done   = 1'b0;
                end
            end else if (in_sys_config) begin
                next_param_cnt = param_cnt + 4'h1;
                if (param_cnt == 4'h0) begin
                    next_pse = 1'b0;
                end
                if (next_param_cnt == SYS_CONFIG_PARAMS) begin
                    next_in_sys_config = 1'b0;
                    next_config_done   = 1'b1;
                end
            end
        end
        unique case (state)
            ST_RUN: begin
                next_tick_seen = 1'b0;
                if (pse) begin
                    next_state = ST_BLANK;
                end
            end
            ST_BLANK: begin
                if (!pse) begin
                    next_state = ST_RUN;
                end else if (frame_tick && tick_seen) begin
                    next_state = ST_SAVE;
                end else if (frame_tick) begin
                    next_tick_seen = 1'b1;
                end
            end
            ST_SAVE: begin
                if (!pse) begin
                    next_state = ST_RUN;
                end
            end
        endcase
    end

    // Registers the sequencer; power-up lands in the low-power state.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state         <= ST_SAVE;
            pse           <= POWER_SAVE_RESET[PSE_BIT];
            tick_seen     <= 1'b0;
            in_sys_config <= 1'b0;
            param_cnt     <= 4'h0;
            config_done   <= 1'b0;
            dummy_pend    <= 2'h0;
            wr_n_d        <= 1'b1;
        end else begin
            state         <= next_state;
            pse           <= next_pse;
            tick_seen     <= next_tick_seen;
            in_sys_config <= next_in_sys_config;
            param_cnt     <= next_param_cnt;
            config_done   <= next_config_done;
            dummy_pend    <= next_dummy_pend;
            wr_n_d        <= wr_n_s;
        end
    end

    // Pins park in power save, while display is off, or before configuration.
    assign park = (state == ST_SAVE) || !display_enable || !config_done;

    pss_scan_t       next_panel;
    pss_mem_t        next_mem;
    logic [DATA_W-1:0] next_bus_out;
    logic            next_bus_oe_n;
    logic            next_wait_oe_n;

    // Computes the pin levels.
    always_comb begin
        next_panel = scan_in;
        if (park) begin
            next_panel = PANEL_PARKED;
        end else if (state == ST_BLANK) begin
            next_panel.panel_pixel_data = 4'h0;
        end
        next_mem       = (state == ST_SAVE) ? mem_out : mem_in;
        next_bus_out   = '0;
        next_bus_out[PSE_BIT] = pse;
        next_wait_oe_n = pse || !display_enable;
        next_bus_oe_n  = 1'b1;
        if (!next_wait_oe_n && !rd_n_s && !cs_n_s && direct_s
            && host_addr == REG_POWER_SAVE_CONTROL) begin
            next_bus_oe_n = 1'b0;
        end
    end

    // Registers every output pin.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            panel_out            <= PANEL_PARKED;
            row_driver_disable_n <= 1'b0;
            mem_out              <= '1;
            host_data_bus_out    <= '0;
            host_data_bus_oe_n   <= 1'b1;
            host_wait_n          <= 1'b1;
            host_wait_oe_n       <= 1'b1;
            scan_clk_en          <= 1'b0;
        end else begin
            panel_out            <= next_panel;
            row_driver_disable_n <= !park;
            mem_out              <= next_mem;
            host_data_bus_out    <= next_bus_out;
            host_data_bus_oe_n   <= next_bus_oe_n;
            host_wait_n          <= 1'b1;
            host_wait_oe_n       <= next_wait_oe_n;
            scan_clk_en          <= (next_state != ST_SAVE);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    save_blanks_row_a: assert property ((state == ST_SAVE) |=> !row_driver_disable_n)
        else $error("Row driver enabled in power save.");
    save_panel_park_a: assert property ((state == ST_SAVE) |=> panel_out == PANEL_PARKED)
        else $error("Panel pins not parked in power save.");
    blank_before_save_a: assert property ($rose(state == ST_SAVE) |-> $past(tick_seen))
        else $error("Low-power state entered without a blanked frame.");
    save_entry_tick_a: assert property ((state == ST_BLANK && pse && frame_tick && tick_seen)
        |=> state == ST_SAVE)
        else $error("Low-power state not taken at second frame end.");
    clear_exits_a: assert property ((state == ST_SAVE && !pse) |=> state == ST_RUN ##1
        scan_clk_en)
        else $error("Clearing the enable bit did not leave power save.");
    bus_float_a: assert property (pse |=> host_wait_oe_n && host_data_bus_oe_n)
        else $error("Host bus driven while power save enabled.");
    mem_hold_a: assert property ((state == ST_SAVE) ##1 (state == ST_SAVE)
        |=> $stable(mem_out))
        else $error("Memory control pins moved in power save.");
    param_one_a: assert property ((wr_strobe && !direct_s && !host_a0 && in_sys_config
        && param_cnt == 4'h0) |=> !pse)
        else $error("First configure parameter did not clear the enable bit.");
    display_off_a: assert property (!display_enable |=> panel_out == PANEL_PARKED
        && host_wait_oe_n)
        else $error("Display off did not park outputs.");
    clocks_stop_a: assert property ((state == ST_SAVE && pse) |=> !scan_clk_en)
        else $error("Internal clocks run in power save.");

    save_entry_c: cover property ((state == ST_BLANK) ##1 (state == ST_SAVE));
    config_done_c: cover property ($rose(config_done));
    blank_abort_c: cover property ((state == ST_BLANK) ##1 (state == ST_RUN));

endmodule

// [testbench.sv]
// Self-checking bench for the LCD power save sequencer.
// Assumes a short frame of 16 cycles and a host model on the parallel bus.
`timescale 1ns/1ps
module testbench
    import pss_pkg::*;
;
    localparam int        FL       = 16;
    localparam pss_scan_t SCAN_RUN = 11'h7ca;

    // One row: byte written to the power save register and the outputs it should give.
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              rdd_n;
        logic              clk_en;
    } pss_row_t;

    logic              clk_sys;
    logic              nrst;
    logic              direct_addressing;
    logic              display_enable;
    pss_scan_t         scan_in;
    pss_mem_t          mem_in;
    logic              host_cs_n, host_wr_n, host_rd_n, host_a0;
    logic [ADDR_W-1:0] host_addr;
    logic [DATA_W-1:0] host_data_bus_in, host_data_bus_out, rdata;
    logic              host_data_bus_oe_n, host_wait_n, host_wait_oe_n, ok;
    logic              scan_clk_en, config_done, row_driver_disable_n;
    pss_scan_t         panel_out;
    pss_mem_t          mem_out;
    int                miscompares = 0;
    int                checks_done = 0;
    pss_row_t          rows [6] = '{'{8'h01, 1'b0, 1'b0}, '{8'h00, 1'b1, 1'b1},
        '{8'h01, 1'b1, 1'b1}, '{8'h01, 1'b0, 1'b0}, '{8'h00, 1'b1, 1'b1},
        '{8'h00, 1'b1, 1'b1}};
    logic [DATA_W-1:0] params [8] = '{8'h30, 8'h87, 8'h07, 8'h27, 8'h34, 8'hc7, 8'h28, 8'h00};

    pss_power_save #(.FRAME_LEN(FL)) u_pss_power_save (.clk_sys(clk_sys), .nrst(nrst),
        .host_cs_n(host_cs_n), .host_wr_n(host_wr_n), .host_rd_n(host_rd_n),
        .host_a0(host_a0), .host_addr(host_addr), .direct_addressing(direct_addressing),
        .host_data_bus_in(host_data_bus_in), .host_data_bus_out(host_data_bus_out),
        .host_data_bus_oe_n(host_data_bus_oe_n), .host_wait_n(host_wait_n),
        .host_wait_oe_n(host_wait_oe_n), .display_enable(display_enable),
        .scan_in(scan_in), .mem_in(mem_in), .scan_clk_en(scan_clk_en),
        .config_done(config_done), .panel_out(panel_out),
        .row_driver_disable_n(row_driver_disable_n), .mem_out(mem_out));

    pss_host_model u_pss_host_model (.clk_sys(clk_sys), .host_cs_n(host_cs_n),
        .host_wr_n(host_wr_n), .host_rd_n(host_rd_n), .host_a0(host_a0),
        .host_addr(host_addr), .host_data_bus_in(host_data_bus_in),
        .host_data_bus_out(host_data_bus_out), .host_data_bus_oe_n(host_data_bus_oe_n));

    // Free running 200 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Compares one value and counts it.
    task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask

    // Waits whole cycles and steps past the edge so outputs have settled.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Checks the parked panel, row driver and floated host lines.
    task automatic chk_parked(input string name);
        chk({name, " panel"}, PANEL_PARKED, panel_out);
        chk({name, " rdd"}, 11'h0, row_driver_disable_n);
        chk({name, " bus oe"}, 11'h1, host_data_bus_oe_n);
        chk({name, " wait oe"}, 11'h1, host_wait_oe_n);
    endtask

    // Holds reset for eight cycles.
    task automatic do_reset();
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        cyc(8);
    endtask

    // Indirect system configure: command and eight parameters.
    task automatic sys_config();
        u_pss_host_model.wr(1'b1, CMD_SYS_CONFIG);
        for (int i = 0; i < 8; i++) begin
            if (i == 7) chk("config before last", 11'h0, config_done);
            u_pss_host_model.wr(1'b0, params[i]);
        end
        chk("config after last", 11'h1, config_done);
        cyc(3 * FL);
        chk("cfg rdd", 11'h1, row_driver_disable_n);
        chk("cfg clk", 11'h1, scan_clk_en);
    endtask

    // Cuts a hang short.
    initial begin
        cyc(10000);
        miscompares++;
        finish_test();
    end

    // Main sequence: reset, table of direct writes, then the awkward cases.
    initial begin
        nrst = 1'b0;
        direct_addressing = 1'b0;
        display_enable = 1'b1;
        scan_in = SCAN_RUN;
        mem_in = 3'b010;
        do_reset();
        chk_parked("reset");
        chk("reset cfg", 11'h0, config_done);
        chk("reset clk", 11'h0, scan_clk_en);
        $display("test reset done");
        sys_config();
        @(posedge clk_sys);
        direct_addressing <= 1'b1;
        cyc(8);
        u_pss_host_model.rd(ok, rdata);
        chk("read pse", 11'h100, {2'b0, ok, rdata});
        chk("wait oe on", 11'h0, host_wait_oe_n);
        chk("wait level", 11'h1, host_wait_n);
        $display("test indirect config done");
        foreach (rows[i]) begin
            u_pss_host_model.wr(1'b0, rows[i].data);
            cyc(3 * FL);
            chk("row rdd", rows[i].rdd_n, row_driver_disable_n);
            chk("row clk", rows[i].clk_en, scan_clk_en);
            chk("row panel", rows[i].rdd_n ? SCAN_RUN : PANEL_PARKED, panel_out);
        end
        $display("test direct rows done");
        u_pss_host_model.wr(1'b0, 8'h01);
        chk("blank pixels", 11'h0, panel_out.panel_pixel_data);
        cyc(FL - 12);
        chk("blank frame rdd", 11'h1, row_driver_disable_n);
        cyc(FL + 12);
        chk("save rdd", 11'h0, row_driver_disable_n);
        @(posedge clk_sys);
        mem_in <= 3'b101;
        cyc(4);
        chk("mem held", 11'h2, mem_out);
        chk_parked("save");
        u_pss_host_model.rd(ok, rdata);
        chk("save read", 11'h0, ok);
        u_pss_host_model.wr(1'b0, 8'h00);
        u_pss_host_model.wr(1'b0, 8'h00);
        cyc(3 * FL);
        chk("mem resumed", 11'h5, mem_out);
        chk("panel resumed", SCAN_RUN, panel_out);
        $display("test frame window done");
        @(posedge clk_sys);
        direct_addressing <= 1'b0;
        cyc(8);
        u_pss_host_model.wr(1'b1, CMD_POWER_SAVE);
        u_pss_host_model.wr(1'b0, 8'h55);
        cyc(3 * FL);
        chk("cmd save rdd", 11'h0, row_driver_disable_n);
        chk("cmd save clk", 11'h0, scan_clk_en);
        sys_config();
        $display("test indirect save done");
        @(posedge clk_sys);
        display_enable <= 1'b0;
        cyc(8);
        chk_parked("display off");
        @(posedge clk_sys);
        display_enable <= 1'b1;
        cyc(3 * FL);
        chk("display on", SCAN_RUN, panel_out);
        do_reset();
        chk_parked("second reset");
        chk("second reset cfg", 11'h0, config_done);
        $display("test display and reset done");
        finish_test();
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
endmodule
